// *** logic/ppo_regs.vh ***
// Purpose: register map, field positions and timing counts of the port block
// Assumes: 32-bit AHB-Lite data, one register per aligned word
// Notes:   include by bare name
`ifndef PPO_REGS_VH
`define PPO_REGS_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define PPO_OFS_OUTPUT      8'h00
`define PPO_OFS_DIRECTION   8'h04
`define PPO_OFS_PIN         8'h08
`define PPO_OFS_CTRL        8'h0c
`define PPO_OFS_IRQ_STATUS  8'h10
`define PPO_OFS_IRQ_CLEAR   8'h14
`define PPO_OFS_IRQ_ENABLE  8'h18
`define PPO_OFS_PC_MASK     8'h1c

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define PPO_CTRL_PUD_BIT    0
`define PPO_CTRL_MODE_LO    1
`define PPO_CTRL_MODE_HI    2
`define PPO_IRQ_EXT0_BIT    0
`define PPO_IRQ_PCHG_BIT    1
`define PPO_EXT0_PIN        6

// ----------------------------------------------------------------------------
// external interrupt sense modes
// ----------------------------------------------------------------------------
`define PPO_MODE_LOW        2'h0
`define PPO_MODE_ANY        2'h1
`define PPO_MODE_FALL       2'h2
`define PPO_MODE_RISE       2'h3

// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
`define PPO_RST_BYTE        8'h00
`define PPO_RST_CTRL        3'h0
`define PPO_RST_IRQ         2'h0
`define PPO_SYNC_STAGES     2

`endif

// *** logic/ppo_sync.v ***
// Purpose: two-flop synchroniser for the eight pad inputs
// Assumes: input is asynchronous to hclk
// Notes:   first stage feeds only the second
`timescale 1ns/100ps

module ppo_sync
(
    // clock and reset
    input  wire       hclk,
    input  wire       hresetn,
    // async in, synced out
    input  wire [7:0] async_in,
    output reg  [7:0] sync_q
);

    reg [7:0] meta_q;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta_q <= 8'h00;
            sync_q <= 8'h00;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

endmodule // ppo_sync

// *** logic/ppo_pin_ctl.v ***
// Purpose: per-pin override equations for pull-up, driver, value and input enable
// Assumes: override pairs come from the peripherals, one bit per pin
// Notes:   purely combinational
`timescale 1ns/100ps

module ppo_pin_ctl
(
    // port register bits
    input  wire [7:0] direction_bit,
    input  wire [7:0] output_bit,
    // shared controls
    input  wire       pullup_global_disable,
    input  wire       reset_active,
    input  wire [7:0] sleep_clamp,
    // peripheral overrides
    input  wire [7:0] pullup_override_en,
    input  wire [7:0] pullup_override_val,
    input  wire [7:0] dir_override_en,
    input  wire [7:0] dir_override_val,
    input  wire [7:0] value_override_en,
    input  wire [7:0] value_override_val,
    input  wire [7:0] input_en_override_en,
    input  wire [7:0] input_en_override_val,
    // pad side
    output wire [7:0] pad_out,
    output wire [7:0] pad_oe_n,
    output wire [7:0] pad_pullup_en,
    output wire [7:0] input_en
);

    wire [7:0] pud_vec = {8{pullup_global_disable}};
    wire [7:0] drive_on;
    wire [7:0] pull_normal;

    // pull-up only for {dir, out, pud} = 0b010
    assign pull_normal = ~direction_bit & output_bit & ~pud_vec;                // [RULE_06] [RULE_17]
    // reset forces pull-ups off whatever the overrides ask
    assign pad_pullup_en = reset_active ? 8'h00 :                               // [RULE_04]
        ((pullup_override_en & pullup_override_val) | // [RULE_06]
         (~pullup_override_en & pull_normal));

    assign drive_on = (dir_override_en & dir_override_val) |
                      (~dir_override_en & direction_bit);                       // [RULE_07]
    // reset tri-states every pin
    assign pad_oe_n = reset_active ? 8'hff : ~drive_on;
    assign pad_out  = drive_on &
        ((value_override_en & value_override_val) | // [RULE_08]
         (~value_override_en & output_bit));

    assign input_en = (input_en_override_en & input_en_override_val) |
                      (~input_en_override_en & ~sleep_clamp);                   // [RULE_10]

endmodule // ppo_pin_ctl

// *** logic/ppo_port.v ***
// Purpose: eight-pin general-purpose port with peripheral overrides and AHB-Lite registers
// Assumes: single clock hclk at 250 MHz, override pairs generated by the peripherals
// Notes:   alternate-function inputs are tapped ahead of the synchroniser
`timescale 1ns/100ps
`include "ppo_regs.vh"

// Overview of operation
// RULE_01: deep sleep clamps each digital input low ahead of the schmitt-trigger.
// RULE_02: pins with their external interrupt enabled escape the sleep clamp.
// RULE_03: disabled edge interrupt pin held high flags itself when clamp lifts; code flags on resume in any-change and rising modes only.
// RULE_04: pull-ups are forced off while reset is asserted.
// RULE_05: software should give unused pins a level, e.g. by pull-up.
// RULE_06: pull-up follows override value, else on only for dir/out/pud 010.
// RULE_07: driver follows direction override value when enabled, else direction bit.
// RULE_08: driven level is value override when enabled, else output bit.
// RULE_09: toggle override enable inverts the pin's output bit.
// RULE_10: input enable follows its override when enabled, else sleep state.
// RULE_11: alternate functions see the input after schmitt, before synchroniser.
// RULE_12: all override signals come from peripherals, not from this block.
// RULE_13: strobes shared per port; clock, clamp and pud shared by ports.
// RULE_14: bit 6 serves analog, timer zero count, ext irq zero, pin change 14.
// RULE_15: bit 2 serves serial clocks, two-wire clock, compare B, pin change 10.
// RULE_16: bit 7 serves reset, single wire debug, analog, pin change 15.
// RULE_17: global pull-up disable turns off every pull-up; code keeps a pull-up on when its override enable and value are both set.
// RULE_18: pin transitions reach the readable input bit through a synchroniser.
module ppo_port
(
    // clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    // pads
    input  wire [7:0]  pad_in,
    output wire [7:0]  pad_out,
    output wire [7:0]  pad_oe_n,
    output wire [7:0]  pad_pullup_en,
    // sleep controller, shared by all ports
    input  wire        sleep_deep,
    // peripheral overrides, one bit per pin
    input  wire [7:0]  pullup_override_en,
    input  wire [7:0]  pullup_override_val,
    input  wire [7:0]  dir_override_en,
    input  wire [7:0]  dir_override_val,
    input  wire [7:0]  value_override_en,
    input  wire [7:0]  value_override_val,
    input  wire [7:0]  toggle_override_en,
    input  wire [7:0]  input_en_override_en,
    input  wire [7:0]  input_en_override_val,
    // alternate-function inputs
    output wire [7:0]  alt_digital_input,
    output wire        timer_zero_count_input,
    output wire        ext_irq_zero_input,
    output wire        pin_change_src_ten,
    output wire        pin_change_src_fourteen,
    output wire        pin_change_src_fifteen,
    output wire        univ_serial_clock,
    output wire        serial_clock_in,
    output wire        two_wire_clock_in,
    output wire        ext_reset_input,
    output wire        single_wire_debug_line,
    // interrupt
    output wire        irq
);

    // ------------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------------
    function [31:0] zext8;
        input [7:0] v;
        begin
            zext8 = {24'h000000, v};
        end
    endfunction

    function hit;
        input [7:0] a;
        input [7:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    reg  [7:0]  output_bit_q;
    reg  [7:0]  output_bit_d;
    reg  [7:0]  direction_bit_q;
    reg  [7:0]  pc_mask_q;
    reg  [2:0]  ctrl_q;
    reg  [1:0]  irq_status_q;
    reg  [1:0]  irq_status_d;
    reg  [1:0]  irq_enable_q;
    reg         wr_q;
    reg  [7:0]  addr_q;
    reg  [7:0]  pin_prev_q;
    reg  [31:0] rd_mux;
    reg         ext0_hit;

    wire        addr_phase;
    wire [7:0]  pin_input_bit;
    wire [7:0]  input_en;
    wire [7:0]  clamped_in;
    wire [7:0]  sleep_clamp;
    wire [7:0]  pin_changed;
    wire        pullup_global_disable;
    wire [1:0]  ext0_mode;
    wire        ext0_req_en;
    wire        wr_output;
    wire        wr_direction;
    wire        wr_pin;
    wire        wr_ctrl;
    wire        wr_clear;
    wire        wr_enable;
    wire        wr_pc_mask;
    wire [1:0]  irq_set;

    // ------------------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------------------
    // never stalls and never errors, so read data is fetched in the address phase
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign addr_phase = hsel & hready & htrans[1];

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q   <= 1'b0;
            addr_q <= 8'h00;
            hrdata <= 32'h00000000;
        end
        else
        begin
            wr_q <= addr_phase & hwrite;
            if (addr_phase)
            begin
                addr_q <= haddr[7:0];
            end
            if (addr_phase & ~hwrite)
            begin
                hrdata <= rd_mux;
            end
        end
    end

    // one strobe set serves all eight pins of the port
    assign wr_output    = wr_q & hit(addr_q, `PPO_OFS_OUTPUT);                  // [RULE_13]
    assign wr_direction = wr_q & hit(addr_q, `PPO_OFS_DIRECTION);
    assign wr_pin       = wr_q & hit(addr_q, `PPO_OFS_PIN);
    assign wr_ctrl      = wr_q & hit(addr_q, `PPO_OFS_CTRL);
    assign wr_clear     = wr_q & hit(addr_q, `PPO_OFS_IRQ_CLEAR);
    assign wr_enable    = wr_q & hit(addr_q, `PPO_OFS_IRQ_ENABLE);
    assign wr_pc_mask   = wr_q & hit(addr_q, `PPO_OFS_PC_MASK);

    always @*
    begin
        rd_mux = 32'h00000000;
        case (haddr[7:0])
            `PPO_OFS_OUTPUT:     rd_mux = zext8(output_bit_q);
            `PPO_OFS_DIRECTION:  rd_mux = zext8(direction_bit_q);
            `PPO_OFS_PIN:        rd_mux = zext8(pin_input_bit);
            `PPO_OFS_CTRL:       rd_mux = zext8({5'h00, ctrl_q});
            `PPO_OFS_IRQ_STATUS: rd_mux = zext8({6'h00, irq_status_q});
            `PPO_OFS_IRQ_ENABLE: rd_mux = zext8({6'h00, irq_enable_q});
            `PPO_OFS_PC_MASK:    rd_mux = zext8(pc_mask_q);
            default:             rd_mux = 32'h00000000;
        endcase
    end

    // ------------------------------------------------------------------------
    // port registers
    // ------------------------------------------------------------------------
    always @*
    begin
        output_bit_d = output_bit_q;
        if (wr_output)
        begin
            output_bit_d = hwdata[7:0];
        end
        // software toggle via pin register and peripheral toggle combine
        output_bit_d = output_bit_d ^ toggle_override_en;                       // [RULE_09]
        if (wr_pin)
        begin
            output_bit_d = output_bit_d ^ hwdata[7:0];
        end
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            output_bit_q    <= `PPO_RST_BYTE;
            direction_bit_q <= `PPO_RST_BYTE;
            pc_mask_q       <= `PPO_RST_BYTE;
            ctrl_q          <= `PPO_RST_CTRL;
            irq_enable_q    <= `PPO_RST_IRQ;
        end
        else
        begin
            output_bit_q <= output_bit_d;
            if (wr_direction)
            begin
                direction_bit_q <= hwdata[7:0];
            end
            if (wr_ctrl)
            begin
                ctrl_q <= hwdata[2:0];
            end
            if (wr_enable)
            begin
                irq_enable_q <= hwdata[1:0];
            end
            if (wr_pc_mask)
            begin
                pc_mask_q <= hwdata[7:0];
            end
        end
    end

    assign pullup_global_disable = ctrl_q[`PPO_CTRL_PUD_BIT];                   // [RULE_17]
    assign ext0_mode             = ctrl_q[`PPO_CTRL_MODE_HI:`PPO_CTRL_MODE_LO];
    assign ext0_req_en           = irq_enable_q[`PPO_IRQ_EXT0_BIT];

    // ------------------------------------------------------------------------
    // pin control
    // ------------------------------------------------------------------------
    // sleep is shared by all pins; only an enabled ext irq pin is exempt
    assign sleep_clamp = {8{sleep_deep}} &                                      // [RULE_01]
        ~({7'h00, ext0_req_en} << `PPO_EXT0_PIN);                               // [RULE_02]

    // overrides arrive from the peripherals and are only applied here
    ppo_pin_ctl u_pin_ctl                                                       // [RULE_12]
    (
        .direction_bit         (direction_bit_q),
        .output_bit            (output_bit_q),
        .pullup_global_disable (pullup_global_disable),
        .reset_active          (~hresetn),
        .sleep_clamp           (sleep_clamp),
        .pullup_override_en    (pullup_override_en),
        .pullup_override_val   (pullup_override_val),
        .dir_override_en       (dir_override_en),
        .dir_override_val      (dir_override_val),
        .value_override_en     (value_override_en),
        .value_override_val    (value_override_val),
        .input_en_override_en  (input_en_override_en),
        .input_en_override_val (input_en_override_val),
        .pad_out               (pad_out),
        .pad_oe_n              (pad_oe_n),
        .pad_pullup_en         (pad_pullup_en),
        .input_en              (input_en)
    );

    // clamp to ground ahead of the schmitt-trigger
    assign clamped_in = pad_in & input_en;                                      // [RULE_01]

    // ------------------------------------------------------------------------
    // input path
    // ------------------------------------------------------------------------
    // flops stand in for latch plus flop, adding up to half a cycle of delay
    ppo_sync u_sync                                                             // [RULE_18]
    (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in (clamped_in),
        .sync_q   (pin_input_bit)
    );

    // unsynchronised tap; receivers synchronise unless used as a clock
    assign alt_digital_input       = clamped_in;                                // [RULE_11]
    assign timer_zero_count_input  = clamped_in[6];                             // [RULE_14]
    assign ext_irq_zero_input      = clamped_in[`PPO_EXT0_PIN];                 // [RULE_14]
    assign pin_change_src_fourteen = clamped_in[6];                             // [RULE_14]
    assign serial_clock_in         = clamped_in[2];                             // [RULE_15]
    assign univ_serial_clock       = clamped_in[2];                             // [RULE_15]
    assign two_wire_clock_in       = clamped_in[2];                             // [RULE_15]
    assign pin_change_src_ten      = clamped_in[2];                             // [RULE_15]
    assign ext_reset_input         = clamped_in[7];                             // [RULE_16]
    assign single_wire_debug_line  = clamped_in[7];                             // [RULE_16]
    assign pin_change_src_fifteen  = clamped_in[7];                             // [RULE_16]

    // ------------------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------------------
    assign pin_changed = (pin_input_bit ^ pin_prev_q) & pc_mask_q;

    // flag sets regardless of enable, so lifting the clamp on a high pin
    // shows as a rising edge on resume
    always @*
    begin
        ext0_hit = 1'b0;
        case (ext0_mode)                                                        // [RULE_03]
            `PPO_MODE_LOW:  ext0_hit = ~pin_input_bit[`PPO_EXT0_PIN];
            `PPO_MODE_ANY:  ext0_hit = pin_input_bit[`PPO_EXT0_PIN] ^
                                       pin_prev_q[`PPO_EXT0_PIN];
            `PPO_MODE_FALL: ext0_hit = ~pin_input_bit[`PPO_EXT0_PIN] &
                                       pin_prev_q[`PPO_EXT0_PIN];
            `PPO_MODE_RISE: ext0_hit = pin_input_bit[`PPO_EXT0_PIN] &
                                       ~pin_prev_q[`PPO_EXT0_PIN];
            default:        ext0_hit = 1'b0;
        endcase
    end

    assign irq_set = {|pin_changed, ext0_hit};

    always @*
    begin
        irq_status_d = irq_status_q;
        if (wr_clear)
        begin
            irq_status_d = irq_status_d & ~hwdata[1:0];
        end
        // a new event beats a clear in the same cycle
        irq_status_d = irq_status_d | irq_set;
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_status_q <= `PPO_RST_IRQ;
            pin_prev_q   <= `PPO_RST_BYTE;
        end
        else
        begin
            irq_status_q <= irq_status_d;
            pin_prev_q   <= pin_input_bit;
        end
    end

    assign irq = |(irq_status_q & irq_enable_q);

endmodule // ppo_port

// *** dv/ppo_chk.sv ***
// Purpose: concurrent checks on the pad side of ppo_port
// Assumes: bound to ppo_port, pad outputs settle between hclk edges
// Notes:   register state is not visible here, the bench covers it
`timescale 1ns/100ps

module ppo_chk
(
    // clock and reset
    input wire logic       hclk,
    input wire logic       hresetn,
    // pads and sleep
    input wire logic [7:0] pad_in,
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe_n,
    input wire logic [7:0] pad_pullup_en,
    input wire logic       sleep_deep,
    // overrides and alternate input
    input wire logic [7:0] pullup_override_en,
    input wire logic [7:0] pullup_override_val,
    input wire logic [7:0] dir_override_en,
    input wire logic [7:0] dir_override_val,
    input wire logic [7:0] value_override_en,
    input wire logic [7:0] value_override_val,
    input wire logic [7:0] input_en_override_en,
    input wire logic [7:0] input_en_override_val,
    input wire logic [7:0] alt_digital_input
);
    // ------------------------------------------------------------------
    // pad relations
    // ------------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // reset checks must run while reset is low, so no disable
    a_reset_pullup_off: assert property (disable iff (1'b0)
        !hresetn |-> pad_pullup_en == 8'h00) else $error("pull-up on in reset");
    a_reset_tristate: assert property (disable iff (1'b0)
        !hresetn ##1 !hresetn |-> pad_oe_n == 8'hff) else $error("driver on in reset");
    a_pullup_ovr: assert property (
        ((pad_pullup_en ^ pullup_override_val) & pullup_override_en) == 8'h00)
        else $error("pull-up ignores override");
    a_dir_ovr: assert property (
        ((~pad_oe_n ^ dir_override_val) & dir_override_en) == 8'h00)
        else $error("driver ignores override");
    a_value_ovr: assert property (
        ((pad_out ^ value_override_val) & value_override_en & ~pad_oe_n) == 8'h00)
        else $error("level ignores override");
    a_input_ovr: assert property (
        ((alt_digital_input ^ (pad_in & input_en_override_val)) & input_en_override_en) == 8'h00)
        else $error("input enable ignores override");
    a_sleep_clamp: assert property (
        sleep_deep |-> (alt_digital_input & ~input_en_override_en & 8'hbf) == 8'h00)
        else $error("input not clamped in sleep");
    a_awake_input: assert property (
        !sleep_deep |-> ((alt_digital_input ^ pad_in)
        & ~(input_en_override_en & ~input_en_override_val)) == 8'h00)
        else $error("alternate input differs from pad");

    c_sleep_high: cover property (sleep_deep && pad_in != 8'h00);
    c_dir_ovr: cover property (dir_override_en != 8'h00);
    c_in_reset: cover property (disable iff (1'b0) !hresetn);
endmodule // ppo_chk

// *** dv/ppo_periph.sv ***
// Purpose: peripheral side producing the per-pin override pairs
// Assumes: pairs change just after a rising hclk edge
// Notes:   random pairs while active, all zero otherwise; toggle_override_en always follows tog_req
`timescale 1ns/100ps

module ppo_periph
(
    // clock and control
    input  wire logic       hclk,
    input  wire logic       active,
    input  wire logic [7:0] tog_req,
    // override pairs, one bit per pin
    output logic      [7:0] pullup_override_en,
    output logic      [7:0] pullup_override_val,
    output logic      [7:0] dir_override_en,
    output logic      [7:0] dir_override_val,
    output logic      [7:0] value_override_en,
    output logic      [7:0] value_override_val,
    output logic      [7:0] toggle_override_en,
    output logic      [7:0] input_en_override_en,
    output logic      [7:0] input_en_override_val
);
    integer      seed = 32'hf38c;
    logic [63:0] rv_q = 64'h0;

    // pairs are owned here, a fresh draw each active cycle per pin
    always @(posedge hclk)
        rv_q <= active ? {$random(seed), $random(seed)} : 64'h0;
    assign {pullup_override_en, pullup_override_val,
            dir_override_en, dir_override_val} = rv_q[63:32];
    assign {value_override_en, value_override_val} = rv_q[31:16];
    assign {input_en_override_en, input_en_override_val} = rv_q[15:0];
    assign toggle_override_en = tog_req;
endmodule // ppo_periph

// *** dv/tb_ppo_port.sv ***
// Purpose: self-checking bench for ppo_port
// Assumes: zero-wait slave, hready fed back from hreadyout
// Notes:   register shadows in integers predict every pad value
`timescale 1ns/100ps

module tb_ppo_port;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, sleep_deep = 0, active = 1;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 3'h2;
    logic        hready, hreadyout, hresp, irq;
    logic [7:0]  pad_in = 0, tog_req = 0, pad_out, pad_oe_n, pad_pullup_en, alt_digital_input;
    logic [7:0]  pullup_override_en, pullup_override_val, dir_override_en, dir_override_val;
    logic [7:0]  value_override_en, value_override_val, toggle_override_en;
    logic [7:0]  input_en_override_en, input_en_override_val;
    logic        timer_zero_count_input, ext_irq_zero_input, pin_change_src_ten;
    logic        pin_change_src_fourteen, pin_change_src_fifteen, univ_serial_clock;
    logic        serial_clock_in, two_wire_clock_in, ext_reset_input, single_wire_debug_line;
    integer      error_cnt = 0, n_tests = 0, seed = 32'hf38c;
    integer      out_m = 0, dir_m = 0, ctrl_m = 0, en_m = 0, i, m;

    assign hready = hreadyout;
    always #2 hclk = ~hclk;
    ppo_port dut (.*);
    ppo_periph periph (.*);

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk(hresp, 1'b0, "hresp");
    endtask

    task check_pads;
        logic [7:0] oe, pu, ie, a;
        @(negedge hclk);
        oe = (dir_override_en & dir_override_val) | (~dir_override_en & dir_m[7:0]);
        pu = ~dir_m[7:0] & out_m[7:0] & {8{~ctrl_m[0]}};
        pu = (pullup_override_en & pullup_override_val) | (~pullup_override_en & pu);
        ie = sleep_deep ? {1'b0, en_m[0], 6'h00} : 8'hff;
        a = pad_in & ((input_en_override_en & input_en_override_val) | (~input_en_override_en & ie));
        chk({~pad_oe_n}, oe, "driver");
        chk(pad_pullup_en, pu, "pullup");
        chk(pad_out, oe & ((value_override_en & value_override_val)
            | (~value_override_en & out_m[7:0])), "level");
        chk(alt_digital_input, a, "alt input");
        chk({timer_zero_count_input, ext_irq_zero_input, pin_change_src_fourteen},
            {3{a[6]}}, "bit6 fanout");
        chk({univ_serial_clock, serial_clock_in, two_wire_clock_in, pin_change_src_ten},
            {4{a[2]}}, "bit2 fanout");
        chk({ext_reset_input, single_wire_debug_line, pin_change_src_fifteen},
            {3{a[7]}}, "bit7 fanout");
        @(posedge hclk);
    endtask

    task irq_step(input logic [7:0] a, input logic [31:0] d, input logic e);
        xfer(a, 1'b1, d);
        @(negedge hclk);
        chk(irq, e, "irq");
        @(posedge hclk);
    endtask

    task results;
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        #80000;
        error_cnt++;
        results;
    end

    initial
    begin
        repeat (2) @(posedge hclk);
        chk(pad_oe_n, 8'hff, "reset driver");
        chk(pad_pullup_en, 8'h00, "reset pullup");
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // unused pins get a level through random pull-up states
        for (i = 0; i < 40; i++)
        begin
            out_m = $random(seed) & 255;
            dir_m = $random(seed) & 255;
            ctrl_m = $random(seed) & 1;
            pad_in <= 8'($random(seed));
            xfer(8'h00, 1'b1, out_m);
            xfer(8'h04, 1'b1, dir_m);
            xfer(8'h0c, 1'b1, ctrl_m);
            check_pads;
        end
        active <= 1'b0;
        xfer(8'h04, 1'b1, 8'hff);
        dir_m = 255;
        tog_req <= 8'h0f;
        @(posedge hclk);
        tog_req <= 8'h00;
        out_m ^= 8'h0f;
        check_pads;
        xfer(8'h08, 1'b1, 8'hf0);
        out_m ^= 8'hf0;
        xfer(8'h00, 1'b0, 0);
        chk(rd, out_m, "output reg");
        pad_in <= 8'ha5;
        repeat (3) @(posedge hclk);
        xfer(8'h08, 1'b0, 0);
        chk(rd, 8'ha5, "pin sync");
        xfer(8'h20, 1'b0, 0);
        chk(rd, 0, "unmapped");
        active <= 1'b1;
        sleep_deep <= 1'b1;
        for (i = 0; i < 16; i++)
        begin
            en_m = i & 1;
            xfer(8'h18, 1'b1, en_m);
            pad_in <= 8'($random(seed));
            check_pads;
        end
        active <= 1'b0;
        sleep_deep <= 1'b0;
        en_m = 0;
        xfer(8'h18, 1'b1, 0);
        for (m = 1; m < 4; m++)
        begin
            xfer(8'h0c, 1'b1, m << 1);
            pad_in <= 8'h40;
            repeat (4) @(posedge hclk);
            sleep_deep <= 1'b1;
            repeat (4) @(posedge hclk);
            xfer(8'h14, 1'b1, 3);
            xfer(8'h10, 1'b0, 0);
            chk(rd[0], 1'b0, "flag in sleep");
            sleep_deep <= 1'b0;
            repeat (4) @(posedge hclk);
            xfer(8'h10, 1'b0, 0);
            chk(rd[0], m != 2, "flag on resume");
            pad_in <= 8'h00;
            repeat (4) @(posedge hclk);
        end
        pad_in <= 8'h40;
        repeat (4) @(posedge hclk);
        xfer(8'h14, 1'b1, 3);
        sleep_deep <= 1'b1;
        repeat (4) @(posedge hclk);
        sleep_deep <= 1'b0;
        repeat (4) @(posedge hclk);
        irq_step(8'h18, 0, 1'b0);
        irq_step(8'h18, 1, 1'b1);
        irq_step(8'h14, 1, 1'b0);
        results;
    end
endmodule // tb_ppo_port

bind ppo_port ppo_chk chk (.*);
